// file: shared/spi_flags_pkg.sv
// Overview of operation
// R1: port_enable set runs the serial logic and gives it the pins; clear disables it.
// R2: stop_in_idle set halts serial logic while cpu idle; clear keeps it running.
// R3: word arriving while receive buffer unread is discarded and sets overflow flag.
// R4: receive_overflow_flag reads 0 unless an overflow has occurred.
// R5: transmit_buffer_full_flag reads 1 while written value waits, shifting not begun.
// R6: transmit_buffer_full_flag reads 0 once shifting began and buffer emptied.
// R7: writing serial_data_buffer sets transmit_buffer_full_flag in hardware.
// R8: receive_buffer_full_flag reads 1 once a completed word sits in the buffer.
// R9: receive_buffer_full_flag reads 0 while reception incomplete and buffer empty.
// R10: moving a completed word from shift register to buffer sets the full flag.
// R11: unimplemented status bits always read zero.
// R12: transmit_buffer_full_flag clears when buffered value moves into shift register.
// R13: reading serial_data_buffer clears receive_buffer_full_flag.
package spi_flags_pkg;
  localparam int ADDR_W = 5;
  localparam int DW = 16;
  localparam int IRQ_W = 3;
  localparam int CNT_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_BUF = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h10;
  localparam int STAT_RBF = 0;
  localparam int STAT_TBF = 1;
  localparam int STAT_OVF = 6;
  localparam int STAT_SIDL = 13;
  localparam int STAT_EN = 15;
  localparam int CTRL_MODE16 = 0;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVF = 2;
  localparam logic [31:0] STAT_MASK = 32'h0000A043;
  localparam logic [DW-1:0] BUF_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic [CNT_W-1:0] BITS_BYTE = 5'h08;
  localparam logic [CNT_W-1:0] BITS_WORD = 5'h10;
endpackage : spi_flags_pkg

// file: hw/spi_pin_sync.sv
module spi_pin_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_type;

  sync_state_type q, d;

  // first stage feeds only the second
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule : spi_pin_sync

// file: hw/spi_shift_engine.sv
module spi_shift_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic sck,
  input wire logic sdi,
  input wire logic ss_n,
  input wire logic mode16,
  input wire logic tx_valid,
  input wire logic [spi_flags_pkg::DW-1:0] tx_data,
  output logic tx_take,
  output logic rx_done,
  output logic [spi_flags_pkg::DW-1:0] rx_word,
  output logic sdo
);
  import spi_flags_pkg::*;

  typedef struct packed {
    logic sck_prev;
    logic loaded;
    logic [CNT_W-1:0] cnt;
    logic [DW-1:0] sh;
    logic take;
    logic done;
  } eng_state_type;

  eng_state_type q, d;

  always_comb begin
    d = q;
    d.take = 1'b0;
    d.done = 1'b0;
    d.sck_prev = sck;
    if (!run || ss_n) begin
      // halted or deselected: any partial word is dropped
      d.cnt = '0;
      d.loaded = 1'b0;
    end else if (!q.loaded) begin
      d.loaded = 1'b1;
      d.take = tx_valid; // see R12
      if (!tx_valid) begin
        d.sh = '0;
      end else if (mode16) begin
        d.sh = tx_data;
      end else begin
        d.sh = {tx_data[7:0], 8'h00};
      end
    end else if (sck && !q.sck_prev) begin
      d.sh = {q.sh[DW-2:0], sdi};
      d.cnt = q.cnt + 5'h01;
      if (d.cnt == (mode16 ? BITS_WORD : BITS_BYTE)) begin
        d.done = 1'b1;
        d.loaded = 1'b0;
        d.cnt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tx_take = q.take;
  assign rx_done = q.done;
  assign rx_word = mode16 ? q.sh : {8'h00, q.sh[7:0]};
  assign sdo = q.sh[DW-1];
endmodule : spi_shift_engine

// file: hw/spi_status_flags.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
module spi_status_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [spi_flags_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in_pin,
  input wire logic slave_select_pin_n,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe_n,
  output logic irq
);
  import spi_flags_pkg::*;

  typedef struct packed {
    logic en;
    logic sidl;
    logic ovf;
    logic tbf;
    logic rbf;
    logic mode16;
    logic [DW-1:0] tx_buf;
    logic [DW-1:0] rx_buf;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sdo;
    logic sdo_oe_n;
  } flags_state_type;

  localparam flags_state_type ST_RST = '{
    tx_buf: BUF_RST,
    rx_buf: BUF_RST,
    irq_st: IRQ_RST,
    irq_mask: IRQ_RST,
    sdo_oe_n: OE_N_RST,
    default: '0
  };

  flags_state_type q, d;

  logic sck_s;
  logic sdi_s;
  logic ss_n_s;
  logic run;
  logic eng_take;
  logic eng_done;
  logic eng_sdo;
  logic [DW-1:0] eng_word;
  logic acc;
  logic wr;
  logic rd_buf;
  logic col;
  logic store;
  logic [IRQ_W-1:0] ev;
  logic apb_setup;
  logic wr_buf;
  logic wr_stat;

  spi_pin_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({serial_clock_pin, serial_data_in_pin, slave_select_pin_n}),
    .dout({sck_s, sdi_s, ss_n_s})
  );

  // idle halt stops the shifter; pins stay owned so the line does not float
  assign run = q.en && !(q.sidl && cpu_idle); // see R1 see R2

  spi_shift_engine u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .sck(sck_s),
    .sdi(sdi_s),
    .ss_n(ss_n_s),
    .mode16(q.mode16),
    .tx_valid(q.tbf),
    .tx_data(q.tx_buf),
    .tx_take(eng_take),
    .rx_done(eng_done),
    .rx_word(eng_word),
    .sdo(eng_sdo)
  );

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {ADDR_STAT, ADDR_CTRL, ADDR_BUF, ADDR_IRQ_ST, ADDR_IRQ_MASK};
  endfunction : mapped

  function automatic logic [31:0] read_mux(input flags_state_type s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      ADDR_STAT: begin
        r[STAT_EN] = s.en;
        r[STAT_SIDL] = s.sidl;
        r[STAT_OVF] = s.ovf;
        r[STAT_TBF] = s.tbf;
        r[STAT_RBF] = s.rbf;
      end
      ADDR_CTRL: r[CTRL_MODE16] = s.mode16;
      ADDR_BUF: r[DW-1:0] = s.rx_buf;
      ADDR_IRQ_ST: r[IRQ_W-1:0] = s.irq_st;
      ADDR_IRQ_MASK: r[IRQ_W-1:0] = s.irq_mask;
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  // no wait state: pready rises in the first access cycle
  assign acc = psel && penable && q.pready;
  assign wr = acc && pwrite && !q.pslverr;
  assign rd_buf = acc && !pwrite && paddr == ADDR_BUF;
  // a read in the same cycle frees the buffer, so that word is kept
  assign col = eng_done && q.rbf && !rd_buf;
  assign store = eng_done && !col;
  assign ev = {col, eng_take, store};
  assign apb_setup = psel && !penable && !q.pready;
  assign wr_buf = wr && paddr == ADDR_BUF;
  assign wr_stat = wr && paddr == ADDR_STAT;

  always_comb begin
    d = q;
    if (apb_setup) begin
      d.pready = 1'b1;
      d.pslverr = !mapped(paddr);
    end else if (acc) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end
    if (wr && paddr == ADDR_STAT) begin
      d.en = pwdata[STAT_EN];
      d.sidl = pwdata[STAT_SIDL];
      if (!pwdata[STAT_OVF]) begin
        d.ovf = 1'b0; // see R4
      end
    end
    if (wr && paddr == ADDR_CTRL) begin
      d.mode16 = pwdata[CTRL_MODE16];
    end
    if (wr && paddr == ADDR_IRQ_MASK) begin
      d.irq_mask = pwdata[IRQ_W-1:0];
    end
    d.irq_st = q.irq_st;
    if (wr && paddr == ADDR_IRQ_ST) begin
      d.irq_st = q.irq_st & ~pwdata[IRQ_W-1:0];
    end
    d.irq_st = d.irq_st | ev;
    if (eng_take) begin
      d.tbf = 1'b0; // see R6 see R12
    end
    if (wr && paddr == ADDR_BUF) begin
      d.tx_buf = pwdata[DW-1:0];
      d.tbf = 1'b1; // see R5 see R7
    end
    if (rd_buf) begin
      d.rbf = 1'b0; // see R9 see R13
    end
    if (store) begin
      d.rx_buf = eng_word;
      d.rbf = 1'b1; // see R8 see R10
    end
    if (col) begin
      d.ovf = 1'b1; // see R3
    end
    // sampled after this edge's updates, so a word stored now is what the read returns
    if (apb_setup) begin
      d.prdata = read_mux(d, paddr); // see R11
    end
    d.irq = |(d.irq_st & d.irq_mask);
    d.sdo = run && eng_sdo;
    d.sdo_oe_n = !(q.en && !ss_n_s); // see R1
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign serial_data_out_pin = q.sdo;
  assign serial_data_out_oe_n = q.sdo_oe_n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_tbf_on_write: assert property ( // see R7
    wr && paddr == ADDR_BUF |=> q.tbf && q.tx_buf == $past(pwdata[DW-1:0], 1))
    else $error("tbf not set by buffer write");

  a_tbf_clear_take: assert property ( // see R12
    eng_take && !(wr && paddr == ADDR_BUF) |=> !q.tbf)
    else $error("tbf not cleared on load");

  a_rbf_on_store: assert property ( // see R10
    eng_done && !q.rbf |=> q.rbf && q.rx_buf == $past(eng_word, 1))
    else $error("received word not stored");

  a_ovf_discard: assert property ( // see R3
    col |=> q.ovf && $stable(q.rx_buf) && q.rbf)
    else $error("overflow not flagged or word not discarded");

  a_ovf_cause: assert property ( // see R4
    $rose(q.ovf) |-> $past(col, 1))
    else $error("overflow flag rose without overflow");

  a_rbf_read_clear: assert property ( // see R13
    rd_buf && !eng_done |=> !q.rbf)
    else $error("rbf not cleared by buffer read");

  a_disabled_pins: assert property ( // see R1
    !q.en |=> serial_data_out_oe_n && !serial_data_out_pin)
    else $error("pins driven while disabled");

  a_idle_halt: assert property ( // see R2
    q.en && q.sidl && cpu_idle |=> !eng_take && !eng_done)
    else $error("shifter ran in idle with stop set");

  a_stat_reserved: assert property ( // see R11
    q.pready && paddr == ADDR_STAT |-> (prdata & ~STAT_MASK) == 32'h00000000)
    else $error("reserved status bit reads one");

  a_apb_wait: assert property (
    psel && !penable && !q.pready |=> pready [*1] ##1 !pready)
    else $error("apb answer timing wrong");

  a_tbf_hold: assert property ( // see R5
    q.tbf && !eng_take |=> q.tbf)
    else $error("tbf dropped before load");

  a_tbf_set_cause: assert property ( // see R6
    $rose(q.tbf) |-> $past(wr_buf, 1))
    else $error("tbf rose without buffer write");

  a_take_needs_tbf: assert property ( // see R12
    eng_take |-> $past(q.tbf, 1))
    else $error("shifter loaded with no value waiting");

  a_rbf_hold: assert property ( // see R8
    q.rbf && !rd_buf |=> q.rbf)
    else $error("rbf dropped without buffer read");

  a_rbf_set_cause: assert property ( // see R9
    $rose(q.rbf) |-> $past(store, 1))
    else $error("rbf rose without stored word");

  a_ovf_sticky: assert property ( // see R3
    q.ovf && !(wr_stat && !pwdata[STAT_OVF]) |=> q.ovf)
    else $error("overflow flag lost");

  a_ovf_clear: assert property ( // see R4
    wr_stat && !pwdata[STAT_OVF] && !col |=> !q.ovf)
    else $error("overflow flag not cleared");

  a_stat_write: assert property ( // see R1 see R2
    wr_stat |=> q.en == $past(pwdata[STAT_EN], 1) && q.sidl == $past(pwdata[STAT_SIDL], 1))
    else $error("enable or idle stop not written");

  a_mode_write: assert property (
    wr && paddr == ADDR_CTRL |=> q.mode16 == $past(pwdata[CTRL_MODE16], 1))
    else $error("word size not written");

  a_enabled_drive: assert property ( // see R1
    q.en && !ss_n_s |=> !serial_data_out_oe_n)
    else $error("data out not driven while selected");

  a_halt_no_shift: assert property ( // see R1 see R2
    !run |=> !eng_take && !eng_done)
    else $error("shifter ran while halted");

  a_halt_sdo_low: assert property ( // see R2
    !run |=> !serial_data_out_pin)
    else $error("data out not low while halted");

  a_rx_event: assert property ( // see R10
    store |=> q.irq_st[IRQ_RX])
    else $error("receive event not recorded");

  a_irq_clear: assert property (
    wr && paddr == ADDR_IRQ_ST && pwdata[IRQ_RX] && !store |=> !q.irq_st[IRQ_RX])
    else $error("receive event not cleared");

  a_apb_err: assert property ( // see R11
    apb_setup && !mapped(paddr) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  c_overflow: cover property (col);
  c_idle_halt: cover property (q.en && q.sidl && cpu_idle && !ss_n_s);
  c_word16: cover property (eng_done && q.mode16);
  c_tx_load: cover property (eng_take ##[1:400] eng_done);
  c_rx_read: cover property (store ##[1:100] rd_buf);
endmodule : spi_status_flags

// file: bench/spi_master_model.sv
module spi_master_model (
  input wire logic pclk,
  input wire logic miso,
  output logic sck,
  output logic mosi,
  output logic ss_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // mode 0, msb first, 16 pclk per link period; slow stretches the low half
  task automatic xfer(input logic [15:0] tx, input int nbits, input int slow,
                      output logic [15:0] rx);
    rx = 16'h0000;
    ss_n <= 1'b0;
    repeat (20) @(posedge pclk);
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8 * slow) @(posedge pclk);
      sck <= 1'b1;
      rx[i] = miso;
      repeat (8) @(posedge pclk);
      sck <= 1'b0;
    end
    repeat (20) @(posedge pclk);
    ss_n <= 1'b1;
    // released line has no pull: show the opposite so stale data cannot pass
    mosi <= ~mosi;
  endtask : xfer
endmodule : spi_master_model

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_flags_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cpu_idle = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, sck, mosi, ss_n, sdo, oe_n, irq, miso;
  logic [15:0] rx;
  int n_mismatch = 0;
  int n_tests = 0;
  // data out line has a pull-up while the device leaves it undriven
  assign miso = oe_n ? 1'b1 : sdo;
  always #5 pclk = ~pclk;
  spi_status_flags i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .serial_clock_pin(sck),
    .serial_data_in_pin(mosi), .slave_select_pin_n(ss_n), .serial_data_out_pin(sdo),
    .serial_data_out_oe_n(oe_n), .irq(irq));
  spi_master_model i_master (.pclk(pclk), .miso(miso), .sck(sck), .mosi(mosi), .ss_n(ss_n));
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_is
  task automatic xf(input logic [15:0] tx, input int nb, input int sl, input logic [15:0] exp);
    i_master.xfer(tx, nb, sl, rx);
    chk({16'h0, rx}, {16'h0, exp});
  endtask : xf
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STAT, 32'h0);
    apb(1'b1, ADDR_STAT, 32'hFFFFFFFF);
    rd(ADDR_STAT, 32'h0000A000);
    apb(1'b0, 5'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, ADDR_STAT, 32'h8000);
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    apb(1'b1, ADDR_BUF, 32'hA5);
    rd(ADDR_STAT, 32'h8002);
    chk({31'h0, oe_n}, 32'h1);
    fork
      xf(16'h3C, 8, 1, 16'hA5);
      begin
        #300;
        chk({31'h0, oe_n}, 32'h0);
      end
    join
    rd(ADDR_STAT, 32'h8001);
    irq_is(1'b1);
    rd(ADDR_IRQ_ST, 32'h3);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    irq_is(1'b1);
    apb(1'b1, ADDR_IRQ_ST, 32'h7);
    irq_is(1'b0);
    xf(16'h77, 8, 1, 16'h0);
    rd(ADDR_STAT, 32'h8041);
    rd(ADDR_BUF, 32'h3C);
    rd(ADDR_STAT, 32'h8040);
    apb(1'b1, ADDR_STAT, 32'h8000);
    rd(ADDR_STAT, 32'h8000);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_BUF, 32'hBEEF);
    xf(16'h1234, 16, 3, 16'hBEEF);
    rd(ADDR_BUF, 32'h1234);
    rd(ADDR_STAT, 32'h8000);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ADDR_STAT, s ? 32'hA000 : 32'h8000);
      @(posedge pclk);
      cpu_idle <= 1'b1;
      xf(16'h5A5A, 16, 1, 16'h0);
      rd(ADDR_STAT, s ? 32'hA000 : 32'h8001);
      @(posedge pclk);
      cpu_idle <= 1'b0;
      apb(1'b0, ADDR_BUF, 32'h0);
    end
    apb(1'b1, ADDR_STAT, 32'h0);
    xf(16'hFFFF, 16, 1, 16'hFFFF);
    rd(ADDR_STAT, 32'h0);
    final_report();
  end
endmodule : testbench
